//--- dcm_consts.svh
// Purpose: register offsets, field positions and reset values for the mode selector
// Assumes: 8-bit byte address on the register bus, 32-bit data
// Notes: reset values are plain starting points for software to overwrite
`ifndef DCM_CONSTS_SVH
`define DCM_CONSTS_SVH

// register byte offsets
`define DCM_CTRL_OFS 8'h00
`define DCM_SQI_OFS 8'h04
`define DCM_ZTHR_OFS 8'h08
`define DCM_BASE_OFS 8'h0c
`define DCM_GAIN_OFS 8'h10
`define DCM_NOTCH_OFS 8'h14
`define DCM_LPF_OFS 8'h18
`define DCM_STAT_OFS 8'h1c
`define DCM_FLUX_OFS 8'h20

// control register bit positions
`define DCM_B_SERVO 0
`define DCM_B_BYREF 1
`define DCM_B_NOTCH 2
`define DCM_B_LPF 3
`define DCM_B_TORQ 4
`define DCM_B_CLAMP 5
`define DCM_B_STSEL 6
`define DCM_B_STINV 7
`define DCM_B_FLUXEXT 8
`define DCM_B_GAINVAR 9

// input-select register field positions
`define DCM_F_LOCK_LSB 0
`define DCM_F_ST_LSB 4

// reset values
`define DCM_CTRL_RST 32'h0000_0000
`define DCM_SQI_RST 32'h0000_0010
`define DCM_ZTHR_RST 16'h0010
`define DCM_BASE_RST 16'h4000
`define DCM_GAIN_RST 16'h1000
`define DCM_COEF_RST 32'h0000_0000
`define DCM_FULL_FLUX 16'h8000

// bus responses
`define DCM_RESP_OK 2'b00
`define DCM_RESP_ERR 2'b10
`endif

//--- dcm_pkg.sv
// Purpose: shared types for the mode selector
// Assumes: speeds are signed 16-bit values
// Notes: one-hot servo-lock states
package dcm_pkg;
  typedef enum logic [2:0] {
    dcm_st_spd = 3'b001,
    dcm_st_wait = 3'b010,
    dcm_st_hold = 3'b100
  } dcm_servo_t;

  typedef logic signed [15:0] dcm_spd_t;

  // magnitude of a signed speed, full scale maps to 16'h8000
  function automatic logic [15:0] dcm_abs(input dcm_spd_t v);
    dcm_abs = v[15] ? 16'(-v) : 16'(v);
  endfunction
endpackage

//--- dcm_servo_fsm.sv
// Purpose: servo-lock sequencing between speed control and position hold
// Assumes: inputs synchronous to aclk
// Notes: state and hold flag are registered
`timescale 1ns/100ps
module dcm_servo_fsm
  import dcm_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic servo_use, // servo-lock configured in use
  input wire logic cmd_by_ref, // 1: speed reference command, 0: external input
  input wire logic speed_ctrl, // controller in speed control
  input wire logic lock_in, // assigned servo-lock input level
  input wire logic ref_zero, // speed reference is zero
  input wire logic stopped, // motor stopped
  output logic hold_ff, // position hold active
  output logic inhibit // speed reference inhibit request
);
  dcm_servo_t state_ff;
  dcm_servo_t nxt_state;
  logic en;
  logic want;

  // lock demanded by the selected source
  assign en = servo_use && speed_ctrl; // [RULE_01]
  assign want = cmd_by_ref ? ref_zero : lock_in;
  assign inhibit = en && !cmd_by_ref && lock_in; // [RULE_02]

  // next state
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      dcm_st_spd:
        if (en && want)
          nxt_state = dcm_st_wait;
      dcm_st_wait:
        if (!en || !want)
          nxt_state = dcm_st_spd;
        else if (stopped)
          nxt_state = dcm_st_hold; // [RULE_03] [RULE_04] [RULE_18]
      dcm_st_hold:
        if (!en || !want)
          nxt_state = dcm_st_spd; // [RULE_05]
      default:
        nxt_state = dcm_st_spd;
    endcase
  end

  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff <= dcm_st_spd;
      hold_ff <= 1'b0;
    end
    else if (ce)
    begin
      state_ff <= nxt_state;
      hold_ff <= (nxt_state == dcm_st_hold);
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_ref_idle;
    ce && en && cmd_by_ref && ref_zero && stopped;
  endsequence

  unused_no_hold_a: assert property ((ce && !servo_use) |=> !hold_ff) // [RULE_01]
    else $error("hold while servo-lock unused");
  hold_after_stop_a: assert property ($rose(hold_ff) |-> $past(stopped)) // [RULE_03]
    else $error("hold entered before stop");
  ref_engage_a: assert property (s_ref_idle ##1 s_ref_idle |=> hold_ff) // [RULE_04]
    else $error("hold not engaged at zero reference");
  ref_release_a: assert property ((ce && cmd_by_ref && !ref_zero) |=> !hold_ff) // [RULE_05]
    else $error("hold not released on reference");
endmodule

//--- dcm_flux_gain.sv
// Purpose: flux ratio and speed loop gain selection
// Assumes: flux ratio 16'h8000 means full flux
// Notes: combinational dividers, one result per enabled cycle
`timescale 1ns/100ps
`include "dcm_consts.svh"
module dcm_flux_gain
  import dcm_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic flux_ext, // 1: external flux ratio reference
  input wire logic gain_var, // 1: gain scaled by flux
  input wire dcm_spd_t speed, // measured speed
  input wire logic [15:0] base_speed, // base speed magnitude
  input wire logic [15:0] ext_flux, // external flux ratio reference
  input wire logic [15:0] gain_base, // nominal speed loop gain
  output logic [15:0] flux_ratio_ff, // present flux ratio
  output logic [15:0] gain_ff // present speed loop gain
);
  logic [15:0] spd_mag;
  logic [31:0] weak_q;
  logic [15:0] flux_spd;
  logic [15:0] flux_nz;
  logic [31:0] gain_q;
  logic [15:0] gain_sat;

  // speed basis: full flux to base speed, weakened as base/speed above it
  assign spd_mag = dcm_abs(speed);
  assign weak_q = {1'b0, base_speed, 15'h0} / {16'h0, spd_mag};
  assign flux_spd = (spd_mag <= base_speed) ? `DCM_FULL_FLUX : weak_q[15:0]; // [RULE_13]

  // gain inversely proportional to the present flux ratio, saturated
  assign flux_nz = (flux_ratio_ff == 16'h0000) ? 16'h0001 : flux_ratio_ff;
  assign gain_q = {1'b0, gain_base, 15'h0} / {16'h0, flux_nz};
  assign gain_sat = (gain_q[31:16] != 16'h0000) ? 16'hffff : gain_q[15:0]; // [RULE_16]

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flux_ratio_ff <= `DCM_FULL_FLUX;
      gain_ff <= `DCM_GAIN_RST;
    end
    else if (ce)
    begin
      flux_ratio_ff <= flux_ext ? ext_flux : flux_spd; // [RULE_13] [RULE_14]
      gain_ff <= gain_var ? gain_sat : gain_base; // [RULE_15] [RULE_16]
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  base_full_a: assert property ((ce && !flux_ext && spd_mag <= base_speed)
    |=> flux_ratio_ff == `DCM_FULL_FLUX) // [RULE_13]
    else $error("flux not full below base speed");
  ext_flux_a: assert property ((ce && flux_ext) |=> flux_ratio_ff == $past(ext_flux)) // [RULE_14]
    else $error("external flux reference not followed");
  fixed_gain_a: assert property ((ce && !gain_var) |=> gain_ff == $past(gain_base)) // [RULE_15]
    else $error("fixed gain changed");
  half_flux_a: assert property ((ce && gain_var && flux_ratio_ff == 16'h4000
    && gain_base < 16'h8000) |=> gain_ff == 16'({$past(gain_base), 1'b0})) // [RULE_16]
    else $error("gain not doubled at half flux");
endmodule

//--- dcm_top.sv
// Purpose: control-mode selection for a motor drive with a register slave
// Assumes: 25 MHz aclk, inputs synchronous, register bus is AXI4-Lite
// Notes: filter arithmetic and clamp limits live downstream; this block
//   hands them enables and coefficients
`timescale 1ns/100ps
`include "dcm_consts.svh"

// Summary of operation
// RULE_01 - servo-lock configured unused: position hold never entered
// RULE_02 - external servo-lock input asserted inhibits the speed reference
// RULE_03 - external servo-lock: position hold only after the motor stops
// RULE_04 - reference servo-lock: hold engages at zero reference and stopped motor
// RULE_05 - reference servo-lock: hold released once reference is nonzero
// RULE_06 - operator uses servo-lock only with speed control, never torque
// RULE_07 - notch filter enable with configured centre rate and Q factor
// RULE_08 - torque low-pass enable with configured corner rate and attenuation
// RULE_09 - operator selects torque reference as source for torque control
// RULE_10 - torque mode runs plain, or speed-clamped when clamp enabled; code clamps only in fixed torque mode, never under input-selected torque
// RULE_11 - normal select polarity: input on gives torque, off gives speed
// RULE_12 - inverted select polarity: input off gives torque, on gives speed
// RULE_13 - speed basis flux: full to base speed, weakened as base/speed above
// RULE_14 - external flux: flux follows the external flux ratio reference
// RULE_15 - fixed gain: speed loop gain constant whatever the flux
// RULE_16 - variable gain: speed loop gain inverse to present flux ratio
// RULE_17 - operator selects flux ratio reference as source for flux control
// RULE_18 - motor stopped when speed magnitude below zero-speed threshold
module dcm_top
  import dcm_pkg::*;
#(
  parameter int ASSIGNABLE_SEQUENCE_INPUT = 8
)
(
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic [ASSIGNABLE_SEQUENCE_INPUT-1:0] assignable_sequence_input, // contact inputs
  input wire dcm_spd_t speed_ref, // speed reference
  input wire dcm_spd_t speed_meas, // measured motor speed
  input wire logic [15:0] ext_flux_ref, // external flux ratio reference
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  output logic [1:0] s_axi_bresp, // write response
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  input wire logic [7:0] s_axi_araddr, // read address
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic pos_hold, // position hold control active
  output logic ref_inhibit, // speed reference inhibited
  output logic torque_ctrl, // torque control active
  output logic speed_clamp_on, // speed clamp applied to torque control
  output logic notch_on, // notch filter enabled
  output logic [15:0] notch_rate, // notch centre angular rate
  output logic [15:0] notch_q, // notch Q factor
  output logic lpf_on, // torque low-pass enabled
  output logic [15:0] lpf_rate, // low-pass corner angular rate
  output logic [15:0] lpf_zeta, // low-pass attenuation constant
  output logic [15:0] flux_ratio, // flux ratio to flux regulator
  output logic [15:0] spd_gain // speed loop gain
);
  localparam int IW = $clog2(ASSIGNABLE_SEQUENCE_INPUT);

  logic [31:0] ctrl_ff;
  logic [31:0] sqi_ff;
  logic [15:0] zthr_ff;
  logic [15:0] base_ff;
  logic [15:0] gain_ff;
  logic [31:0] notch_ff;
  logic [31:0] lpf_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic inhibit_ff;
  logic torque_ff;
  logic clamp_ff;
  logic stopped_ff;
  logic fsm_hold;
  logic fsm_inhibit;

  // byte-lane merge for register writes
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      wmerge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
  endfunction

  // write channel handshakes and decode
  wire aw_take = s_axi_awvalid && awready_ff;
  wire w_take = s_axi_wvalid && wready_ff;
  wire wr_go = aw_got_ff && w_got_ff && !bvalid_ff;
  wire b_done = bvalid_ff && s_axi_bready;
  wire nxt_aw_got = !wr_go && (aw_got_ff || aw_take);
  wire nxt_w_got = !wr_go && (w_got_ff || w_take);
  wire nxt_bvalid = wr_go || (bvalid_ff && !b_done);
  wire wr_ctrl = wr_go && (awaddr_ff == `DCM_CTRL_OFS);
  wire wr_sqi = wr_go && (awaddr_ff == `DCM_SQI_OFS);
  wire wr_zthr = wr_go && (awaddr_ff == `DCM_ZTHR_OFS);
  wire wr_base = wr_go && (awaddr_ff == `DCM_BASE_OFS);
  wire wr_gain = wr_go && (awaddr_ff == `DCM_GAIN_OFS);
  wire wr_notch = wr_go && (awaddr_ff == `DCM_NOTCH_OFS);
  wire wr_lpf = wr_go && (awaddr_ff == `DCM_LPF_OFS);
  wire wr_hit = wr_ctrl || wr_sqi || wr_zthr || wr_base || wr_gain || wr_notch || wr_lpf;

  // read channel handshakes and selection
  wire ar_take = s_axi_arvalid && arready_ff;
  wire nxt_rvalid = ar_take || (rvalid_ff && !s_axi_rready);
  wire [31:0] stat_word = {27'h0, stopped_ff, clamp_ff, torque_ff, inhibit_ff, fsm_hold};
  wire rd_hit = (s_axi_araddr <= `DCM_FLUX_OFS) && (s_axi_araddr[1:0] == 2'b00);
  wire [31:0] rd_mux =
    (s_axi_araddr == `DCM_CTRL_OFS) ? ctrl_ff :
    (s_axi_araddr == `DCM_SQI_OFS) ? sqi_ff :
    (s_axi_araddr == `DCM_ZTHR_OFS) ? {16'h0, zthr_ff} :
    (s_axi_araddr == `DCM_BASE_OFS) ? {16'h0, base_ff} :
    (s_axi_araddr == `DCM_GAIN_OFS) ? {16'h0, gain_ff} :
    (s_axi_araddr == `DCM_NOTCH_OFS) ? notch_ff :
    (s_axi_araddr == `DCM_LPF_OFS) ? lpf_ff :
    (s_axi_araddr == `DCM_STAT_OFS) ? stat_word :
    (s_axi_araddr == `DCM_FLUX_OFS) ? {spd_gain, flux_ratio} : 32'h0000_0000;

  // control field decode
  wire servo_use = ctrl_ff[`DCM_B_SERVO];
  wire cmd_by_ref = ctrl_ff[`DCM_B_BYREF];
  wire torque_mode = ctrl_ff[`DCM_B_TORQ];
  wire clamp_en = ctrl_ff[`DCM_B_CLAMP];
  wire st_sel_en = ctrl_ff[`DCM_B_STSEL];
  wire st_invert = ctrl_ff[`DCM_B_STINV];
  wire [IW-1:0] lock_idx = sqi_ff[`DCM_F_LOCK_LSB +: IW];
  wire [IW-1:0] st_idx = sqi_ff[`DCM_F_ST_LSB +: IW];
  wire sqi_lock = assignable_sequence_input[lock_idx];
  wire sqi_st = assignable_sequence_input[st_idx];

  // mode selection: fixed torque mode, or input-driven select of either polarity
  wire torque_act = torque_mode || (st_sel_en && (sqi_st ^ st_invert)); // [RULE_11] [RULE_12]
  wire clamp_act = torque_mode && clamp_en; // [RULE_10]
  wire stopped = dcm_abs(speed_meas) < zthr_ff; // [RULE_18]
  wire ref_zero = (speed_ref == 16'sh0000);

  // bus slave registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= `DCM_RESP_OK;
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `DCM_RESP_OK;
    end
    else if (ce)
    begin
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      if (aw_take)
        awaddr_ff <= s_axi_awaddr;
      if (w_take)
      begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      awready_ff <= !nxt_aw_got && !nxt_bvalid;
      wready_ff <= !nxt_w_got && !nxt_bvalid;
      bvalid_ff <= nxt_bvalid;
      if (wr_go)
        bresp_ff <= wr_hit ? `DCM_RESP_OK : `DCM_RESP_ERR;
      arready_ff <= !nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_take)
      begin
        rdata_ff <= rd_mux;
        rresp_ff <= rd_hit ? `DCM_RESP_OK : `DCM_RESP_ERR;
      end
    end
  end

  // configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_ff <= `DCM_CTRL_RST;
      sqi_ff <= `DCM_SQI_RST;
      zthr_ff <= `DCM_ZTHR_RST;
      base_ff <= `DCM_BASE_RST;
      gain_ff <= `DCM_GAIN_RST;
      notch_ff <= `DCM_COEF_RST;
      lpf_ff <= `DCM_COEF_RST;
    end
    else if (ce)
    begin
      if (wr_ctrl)
        ctrl_ff <= wmerge(ctrl_ff, wdata_ff, wstrb_ff) & 32'h0000_03ff;
      if (wr_sqi)
        sqi_ff <= wmerge(sqi_ff, wdata_ff, wstrb_ff) & 32'h0000_0077;
      if (wr_zthr)
        zthr_ff <= 16'(wmerge({16'h0, zthr_ff}, wdata_ff, wstrb_ff));
      if (wr_base)
        base_ff <= 16'(wmerge({16'h0, base_ff}, wdata_ff, wstrb_ff));
      if (wr_gain)
        gain_ff <= 16'(wmerge({16'h0, gain_ff}, wdata_ff, wstrb_ff));
      if (wr_notch)
        notch_ff <= wmerge(notch_ff, wdata_ff, wstrb_ff);
      if (wr_lpf)
        lpf_ff <= wmerge(lpf_ff, wdata_ff, wstrb_ff);
    end
  end

  // registered mode outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      inhibit_ff <= 1'b0;
      torque_ff <= 1'b0;
      clamp_ff <= 1'b0;
      stopped_ff <= 1'b0;
    end
    else if (ce)
    begin
      inhibit_ff <= fsm_inhibit; // [RULE_02]
      torque_ff <= torque_act; // [RULE_10] [RULE_11] [RULE_12]
      clamp_ff <= clamp_act; // [RULE_10]
      stopped_ff <= stopped; // [RULE_18]
    end
  end

  dcm_servo_fsm u_servo (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .servo_use(servo_use),
    .cmd_by_ref(cmd_by_ref),
    .speed_ctrl(!torque_act),
    .lock_in(sqi_lock),
    .ref_zero(ref_zero),
    .stopped(stopped),
    .hold_ff(fsm_hold),
    .inhibit(fsm_inhibit)
  );

  dcm_flux_gain u_flux (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .flux_ext(ctrl_ff[`DCM_B_FLUXEXT]),
    .gain_var(ctrl_ff[`DCM_B_GAINVAR]),
    .speed(speed_meas),
    .base_speed(base_ff),
    .ext_flux(ext_flux_ref),
    .gain_base(gain_ff),
    .flux_ratio_ff(flux_ratio),
    .gain_ff(spd_gain)
  );

  // port drive, all from flip-flops
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign pos_hold = fsm_hold;
  assign ref_inhibit = inhibit_ff;
  assign torque_ctrl = torque_ff;
  assign speed_clamp_on = clamp_ff;
  assign notch_on = ctrl_ff[`DCM_B_NOTCH]; // [RULE_07]
  assign notch_rate = notch_ff[15:0]; // [RULE_07]
  assign notch_q = notch_ff[31:16];
  assign lpf_on = ctrl_ff[`DCM_B_LPF]; // [RULE_08]
  assign lpf_rate = lpf_ff[15:0]; // [RULE_08]
  assign lpf_zeta = lpf_ff[31:16];

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  ext_inhibit_a: assert property ((ce && servo_use && !cmd_by_ref && !torque_act && sqi_lock)
    |=> ref_inhibit) // [RULE_02]
    else $error("reference not inhibited by servo-lock input");
  clamp_mode_a: assert property ((ce && torque_mode)
    |=> torque_ctrl && speed_clamp_on == $past(clamp_en)) // [RULE_10]
    else $error("torque mode or clamp wrong");
  sel_normal_a: assert property ((ce && !torque_mode && st_sel_en && !st_invert)
    |=> torque_ctrl == $past(sqi_st) && !speed_clamp_on) // [RULE_11]
    else $error("normal select polarity wrong");
  sel_invert_a: assert property ((ce && !torque_mode && st_sel_en && st_invert)
    |=> torque_ctrl == !$past(sqi_st)) // [RULE_12]
    else $error("inverted select polarity wrong");
  notch_cfg_a: assert property ((ce && wr_notch && wstrb_ff == 4'hf)
    |=> notch_rate == $past(wdata_ff[15:0]) && notch_q == $past(wdata_ff[31:16])) // [RULE_07]
    else $error("notch coefficients not loaded");
  lpf_cfg_a: assert property ((ce && wr_ctrl && wstrb_ff[0])
    |=> lpf_on == $past(wdata_ff[`DCM_B_LPF])) // [RULE_08]
    else $error("low-pass enable not loaded");
  zero_speed_a: assert property ((ce && dcm_abs(speed_meas) >= zthr_ff) |=> !stopped_ff) // [RULE_18]
    else $error("stopped flagged above threshold");
endmodule

//--- dcm_contacts.sv
// Purpose: contact inputs and operator references seen by the mode selector
// Assumes: bench requests new levels, applied at the next edge
// Notes: contacts are plain levels, never released
`timescale 1ns/100ps
module dcm_contacts
  import dcm_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic [7:0] want_sqi, // requested contact levels
  input wire dcm_spd_t want_ref, // requested speed reference
  input wire dcm_spd_t want_meas, // requested motor speed
  input wire logic [15:0] want_flux, // requested flux ratio reference
  output logic [7:0] assignable_sequence_input = 8'h00, // contacts
  output dcm_spd_t speed_ref = 16'sh0000, // speed reference
  output dcm_spd_t speed_meas = 16'sh0000, // motor speed
  output logic [15:0] ext_flux_ref = 16'h8000 // flux ratio reference
);
  // operator feeds only the source each mode needs, servo-lock in speed mode
  always_ff @(posedge aclk)
  begin
    assignable_sequence_input <= want_sqi;
    speed_ref <= want_ref;
    speed_meas <= want_meas;
    ext_flux_ref <= want_flux;
  end
endmodule

//--- test_drive_control_mode_select.sv
// Purpose: self-checking bench for the drive mode selector
// Assumes: 25 MHz clock, registers reached over AXI4-Lite
// Notes: expected values come from integer models in this file
`timescale 1ns/100ps
`include "dcm_consts.svh"
module test_drive_control_mode_select;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] want_sqi = 8'h00;
  dcm_pkg::dcm_spd_t want_ref = 16'sh0000;
  dcm_pkg::dcm_spd_t want_meas = 16'sh0000;
  logic [15:0] want_flux = 16'h8000;
  logic [7:0] assignable_sequence_input;
  dcm_pkg::dcm_spd_t speed_ref, speed_meas;
  logic [15:0] ext_flux_ref;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic pos_hold, ref_inhibit, torque_ctrl, speed_clamp_on, notch_on, lpf_on;
  logic [15:0] notch_rate, notch_q, lpf_rate, lpf_zeta, flux_ratio, spd_gain;
  int n_fail = 0;
  int tests_run = 0;
  int m, f, g, c;
  // far side and the block under test
  dcm_contacts i_src (.aclk, .want_sqi, .want_ref, .want_meas, .want_flux,
    .assignable_sequence_input, .speed_ref, .speed_meas, .ext_flux_ref);
  dcm_top i_dut (.aclk, .aresetn, .ce, .assignable_sequence_input, .speed_ref, .speed_meas,
    .ext_flux_ref, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .pos_hold, .ref_inhibit, .torque_ctrl, .speed_clamp_on,
    .notch_on, .notch_rate, .notch_q, .lpf_on, .lpf_rate, .lpf_zeta, .flux_ratio, .spd_gain);
  // 40 ns clock
  always #20 aclk = ~aclk;
  task automatic give_verdict;
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic hang;
    n_fail++;
    $display("mismatch at %0t: bus answer missing", $time);
    give_verdict();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
        break;
    end
    if (n == 40)
      hang();
    chk(32'(s_axi_bresp), 32'(r)); // bready stays up until the next call
  endtask
  // read: data and response taken at the rvalid edge
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
        break;
    end
    if (n == 40)
      hang();
    chk(s_axi_rdata, d); // rready stays up until the next call
    chk(32'(s_axi_rresp), 32'(r));
  endtask
  // main sequence
  initial
  begin
    void'($urandom(36676));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, unmapped and read-only places
    rd(`DCM_CTRL_OFS, `DCM_CTRL_RST, `DCM_RESP_OK);
    rd(`DCM_SQI_OFS, `DCM_SQI_RST, `DCM_RESP_OK);
    rd(`DCM_ZTHR_OFS, 32'(`DCM_ZTHR_RST), `DCM_RESP_OK);
    rd(8'h40, 32'h0, `DCM_RESP_ERR);
    wr(`DCM_STAT_OFS, 32'hffff_ffff, `DCM_RESP_ERR);
    // fixed torque mode, clamp off then on
    for (c = 0; c < 2; c++)
    begin
      wr(`DCM_CTRL_OFS, 32'h10 | (32'(c) << 5), `DCM_RESP_OK);
      tick(3);
      chk(torque_ctrl, 1);
      chk(speed_clamp_on, c);
    end
    // input-selected mode, both polarities and both levels
    for (c = 0; c < 4; c++)
    begin
      wr(`DCM_CTRL_OFS, 32'h40 | (32'(c / 2) << 7), `DCM_RESP_OK);
      want_sqi <= 8'((c % 2) * 2);
      tick(4);
      chk(torque_ctrl, (c % 2) ^ (c / 2));
    end
    // clock enable low: inverted select must not follow the input change
    ce <= 1'b0;
    want_sqi <= 8'h00;
    tick(4);
    chk(torque_ctrl, 0);
    ce <= 1'b1;
    tick(3);
    chk(torque_ctrl, 1);
    // servo-lock unused: no hold at zero reference and stopped motor
    want_sqi <= 8'h01;
    wr(`DCM_CTRL_OFS, 32'h0, `DCM_RESP_OK);
    tick(6);
    chk(pos_hold, 0);
    // external command: inhibit at once, hold only once stopped
    want_meas <= 16'sd500;
    wr(`DCM_CTRL_OFS, 32'h1, `DCM_RESP_OK);
    tick(6);
    chk(ref_inhibit, 1);
    chk(pos_hold, 0);
    want_meas <= 16'sd15;
    tick(6);
    chk(pos_hold, 1);
    // reference command: threshold edge, engage, release
    want_sqi <= 8'h00;
    want_meas <= 16'sd16;
    wr(`DCM_CTRL_OFS, 32'h0, `DCM_RESP_OK);
    wr(`DCM_CTRL_OFS, 32'h3, `DCM_RESP_OK);
    tick(6);
    chk(pos_hold, 0);
    want_meas <= -16'sd15;
    tick(6);
    chk(pos_hold, 1);
    want_ref <= 16'sd1;
    tick(3);
    chk(pos_hold, 0);
    // filter enables and random coefficients
    for (c = 0; c < 4; c++)
    begin
      m = $urandom;
      f = $urandom;
      wr(`DCM_NOTCH_OFS, m, `DCM_RESP_OK);
      wr(`DCM_LPF_OFS, f, `DCM_RESP_OK);
      wr(`DCM_CTRL_OFS, 32'(c) << 2, `DCM_RESP_OK);
      tick(3);
      chk(notch_on, c % 2);
      chk({notch_q, notch_rate}, m);
      chk(lpf_on, c / 2);
      chk({lpf_zeta, lpf_rate}, f);
    end
    // flux source and gain law, base speed edges then random speeds
    for (c = 0; c < 8; c++)
    begin
      m = (c < 4) ? 16383 + c : $urandom_range(32767);
      f = $urandom_range(32768, 1024);
      want_meas <= 16'(c[2] ? -m : m);
      want_flux <= 16'(f);
      wr(`DCM_CTRL_OFS, 32'(c % 4) << 8, `DCM_RESP_OK);
      tick(6);
      if (c % 2 == 0)
        f = (m > 16384) ? (16384 * 32768) / m : 32768;
      g = (134217728 / f > 65535) ? 65535 : 134217728 / f;
      chk(flux_ratio, f);
      chk(spd_gain, ((c / 2) % 2 == 0) ? 4096 : g);
    end
    give_verdict();
  end
endmodule
